// ==== hdl/uart_stop_loop_single_wire.sv ====
// Serial port core with deep-sleep edge wake-up, loop and single-wire routing.
// Assumes a power controller raising i_stop_req while the module clock keeps running.
//
// Summary of operation
// - In stop mode the shifters and module logic stand still, apart from the pin synchronisers, edge detector and read data (cleared).
// - Deep sleep leaves every module register but the pin synchronisers, edge detector and read data (cleared) as it was.
// - The receive-line edge detector keeps running through deep sleep.
// - A deep-sleep edge wakes the processor only with rx_edge_irq_en set.
// - After deep sleep the module resumes from its preserved state.
// - With loopback_on, rx_source_sel 0 picks loop mode, 1 single-wire mode.
// - Loop mode feeds the receiver from the transmitter output internally.
// - Single-wire mode ties receiver to transmitter output and serial_out_pin.
// - Single-wire mode releases serial_in_pin to general-purpose use.
// - Single-wire with one_wire_out_dir clear makes serial_out_pin a receiver input.
// - Single-wire with one_wire_out_dir set drives serial_out_pin from the transmitter.
// - With rx_on, a receive-line falling edge sets rx_edge_flag; write 1 clears.
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module uart_stop_loop_single_wire
  import uart_sw_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Register port
  input wire uart_sw_pkg::reg_req_t i_req,
  output logic [uart_sw_pkg::DATA_W-1:0] o_rdata,
  // Power control
  input wire logic i_stop_req,
  output logic o_wake,
  // Serial pins
  input wire logic i_serial_in_pin,
  output logic o_serial_in_release,
  input wire logic i_serial_out_pin,
  output logic o_serial_out,
  output logic o_serial_out_oe_b,
  // Interrupt
  output logic o_irq
);
  import uart_sw_pkg::*;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } rx_state_t;

  ctrl_t ctrl_q;
  logic [7:0] baud_q;
  logic [7:0] baud_cnt_q;
  logic tick;
  logic run;
  logic [7:0] tx_buf_q;
  logic tx_empty_q;
  logic tx_load;
  logic tx_line;
  logic tx_busy;
  logic tx_done;
  logic in_level;
  logic out_level;
  logic rx_in;
  logic rx_prev_q;
  logic rx_fall;
  logic single_wire;
  rx_state_t rx_state_q;
  logic [3:0] rx_tick_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_shift_q;
  logic [7:0] rx_data_q;
  logic rx_full_q;
  logic overrun_q;
  logic rx_done;
  logic edge_pend_q;
  logic [IRQ_N-1:0] irq_stat_q;
  logic [IRQ_N-1:0] irq_en_q;
  logic [IRQ_N-1:0] irq_set;
  logic [IRQ_N-1:0] irq_clr;
  logic [7:0] rdata_q;
  logic wr_ok;
  logic rd_ok;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // Clock gating and routing
  // ----------------------------------------------------------------
  // Module logic advances only out of stop, so all state but the pin synchronisers, edge detector and read data (cleared to zero) is frozen
  assign run = !i_stop_req;
  assign wr_ok = run && i_req.wr;
  assign rd_ok = run && i_req.rd;
  assign single_wire = ctrl_q.loopback_on && ctrl_q.rx_source_sel;

  uart_pin_sync u_in_sync
  (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_pin(i_serial_in_pin),
    .o_level(in_level)
  );

  uart_pin_sync u_out_sync
  (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_pin(i_serial_out_pin),
    .o_level(out_level)
  );

  // Receiver source selection
  always_comb
  begin
    if (!ctrl_q.loopback_on)
      rx_in = in_level;
    else if (!ctrl_q.rx_source_sel)
      rx_in = tx_line;
    else if (ctrl_q.one_wire_out_dir)
      rx_in = tx_line;
    else
      rx_in = out_level;
  end

  // Pin drive: loop mode still drives the pin, single-wire follows direction
  assign o_serial_out = tx_line;
  assign o_serial_out_oe_b = single_wire && !ctrl_q.one_wire_out_dir;
  assign o_serial_in_release = single_wire;

  // ----------------------------------------------------------------
  // Baud divider
  // ----------------------------------------------------------------
  assign tick = run && (baud_cnt_q == baud_q);

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      baud_cnt_q <= 8'h00;
    else if (run)
      baud_cnt_q <= (baud_cnt_q == baud_q) ? 8'h00 : baud_cnt_q + 8'h01;
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ctrl_q <= ctrl_t'(CTRL_RST);
      baud_q <= BAUD_RST;
      irq_en_q <= IRQ_EN_RST;
    end
    else if (wr_ok)
    begin
      if (hit(i_req.addr, OFF_CTRL))
        ctrl_q <= ctrl_t'({3'h0, i_req.wdata[4:0]});
      if (hit(i_req.addr, OFF_BAUD))
        baud_q <= i_req.wdata;
      if (hit(i_req.addr, OFF_IRQ_EN))
        irq_en_q <= i_req.wdata[IRQ_N-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------
  assign tx_load = run && !tx_empty_q && !tx_busy && ctrl_q.tx_on;

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tx_buf_q <= 8'h00;
      tx_empty_q <= 1'b1;
    end
    else if (run)
    begin
      if (wr_ok && hit(i_req.addr, OFF_DATA))
      begin
        tx_buf_q <= i_req.wdata;
        tx_empty_q <= 1'b0;
      end
      else if (tx_load)
        tx_empty_q <= 1'b1;
    end
  end

  uart_tx_shift u_tx
  (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_run(run),
    .i_tick(tick),
    .i_load(tx_load),
    .i_data(tx_buf_q),
    .o_line(tx_line),
    .o_busy(tx_busy),
    .o_done(tx_done)
  );

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_state_q <= RX_IDLE;
      rx_tick_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_shift_q <= 8'h00;
    end
    else if (run && !ctrl_q.rx_on)
      rx_state_q <= RX_IDLE;
    else if (tick)
    begin
      rx_tick_q <= rx_tick_q + 4'h1;
      unique case (rx_state_q)
        RX_IDLE:
        begin
          rx_tick_q <= 4'h0;
          if (!rx_in)
            rx_state_q <= RX_START;
        end
        RX_START:
          if (rx_tick_q == 4'(SAMPLE_POINT - 1))
          begin
            rx_tick_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_state_q <= rx_in ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (rx_tick_q == 4'(OVERSAMPLE - 1))
          begin
            rx_shift_q <= {rx_in, rx_shift_q[7:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == 4'(CHAR_BITS - 1))
              rx_state_q <= RX_STOP;
          end
        RX_STOP:
          if (rx_tick_q == 4'(OVERSAMPLE - 1))
            rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // A frame with a low stop bit is dropped
  assign rx_done = tick && ctrl_q.rx_on && (rx_state_q == RX_STOP)
                   && (rx_tick_q == 4'(OVERSAMPLE - 1)) && rx_in;

  // Reading the data register empties it; a new frame wins over that read
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_data_q <= 8'h00;
      rx_full_q <= 1'b0;
      overrun_q <= 1'b0;
    end
    else if (run)
    begin
      if (rx_done && rx_full_q && !(rd_ok && hit(i_req.addr, OFF_DATA)))
        overrun_q <= 1'b1;
      else if (rx_done)
      begin
        rx_data_q <= rx_shift_q;
        rx_full_q <= 1'b1;
      end
      else if (rd_ok && hit(i_req.addr, OFF_DATA))
      begin
        rx_full_q <= 1'b0;
        overrun_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Edge detector and wake-up
  // ----------------------------------------------------------------
  // Runs on the always-on clock so it keeps watching while the core is frozen
  assign rx_fall = rx_prev_q && !rx_in;

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      rx_prev_q <= 1'b1;
    else
      rx_prev_q <= rx_in;
  end

  // Edges in stop are held aside and folded into the flag on exit
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      edge_pend_q <= 1'b0;
    else if (i_stop_req && ctrl_q.rx_on && rx_fall)
      edge_pend_q <= 1'b1;
    else if (run)
      edge_pend_q <= 1'b0;
  end

  assign o_wake = i_stop_req && edge_pend_q && irq_en_q[IRQ_RX_EDGE];

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  assign irq_set[IRQ_RX_EDGE] = (ctrl_q.rx_on && rx_fall) || edge_pend_q;
  assign irq_set[IRQ_TX_DONE] = tx_done;
  assign irq_set[IRQ_RX_FULL] = rx_done;
  assign irq_clr = (wr_ok && hit(i_req.addr, OFF_IRQ_CLR)) ? i_req.wdata[IRQ_N-1:0] : '0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      irq_stat_q <= '0;
    else if (run)
      irq_stat_q <= irq_set | (irq_stat_q & ~irq_clr);
  end

  assign o_irq = |(irq_stat_q & irq_en_q);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Status gives software what it must check before requesting stop
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      rdata_q <= RDATA_RST;
    else if (rd_ok)
    begin
      unique case (i_req.addr)
        OFF_CTRL: rdata_q <= ctrl_q;
        OFF_STAT: rdata_q <= {3'h0, overrun_q, rx_full_q, rx_state_q != RX_IDLE,
                              tx_empty_q && !tx_busy, tx_empty_q};
        OFF_DATA: rdata_q <= rx_data_q;
        OFF_BAUD: rdata_q <= baud_q;
        OFF_IRQ_STAT: rdata_q <= {5'h00, irq_stat_q};
        OFF_IRQ_EN: rdata_q <= {5'h00, irq_en_q};
        default: rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end

  assign o_rdata = rdata_q;

endmodule
`default_nettype wire

// ==== shared/uart_sw_pkg.sv ====
// Constants, register map and carrier types for the serial port with
// loop-back, single-wire routing and deep-sleep edge wake-up.
// Assumes one module clock and an 8-bit register port with 3-bit address.
package uart_sw_pkg;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  localparam logic [2:0] OFF_CTRL = 3'h0;
  localparam logic [2:0] OFF_STAT = 3'h1;
  localparam logic [2:0] OFF_DATA = 3'h2;
  localparam logic [2:0] OFF_BAUD = 3'h3;
  localparam logic [2:0] OFF_IRQ_STAT = 3'h4;
  localparam logic [2:0] OFF_IRQ_CLR = 3'h5;
  localparam logic [2:0] OFF_IRQ_EN = 3'h6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STAT_TX_EMPTY = 0;
  localparam int STAT_TX_DONE = 1;
  localparam int STAT_RX_BUSY = 2;
  localparam int STAT_RX_FULL = 3;
  localparam int STAT_OVERRUN = 4;

  localparam int IRQ_RX_EDGE = 0;
  localparam int IRQ_TX_DONE = 1;
  localparam int IRQ_RX_FULL = 2;
  localparam int IRQ_N = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [2:0] IRQ_EN_RST = 3'h0;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // ----------------------------------------------------------------
  // Character timing
  // ----------------------------------------------------------------
  localparam int OVERSAMPLE = 16;
  localparam int SAMPLE_POINT = 8;
  localparam int CHAR_BITS = 8;
  localparam int FRAME_BITS = 10;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] rsvd;
    logic one_wire_out_dir;
    logic rx_source_sel;
    logic loopback_on;
    logic tx_on;
    logic rx_on;
  } ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// ==== hdl/uart_pin_sync.sv ====
// Three-stage synchroniser for a pin level with a two-stage agreement filter.
// Assumes the pin is asynchronous to i_mclk and idles high.
`timescale 1ns/10ps
`default_nettype none
module uart_pin_sync
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Pin and filtered level
  input wire logic i_pin,
  output logic o_level
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end
    else
    begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change is accepted only once the last two stages agree
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      level_q <= 1'b1;
    else if (s2_q == s3_q)
      level_q <= s3_q;
  end

  assign o_level = level_q;

endmodule
`default_nettype wire

// ==== hdl/uart_tx_shift.sv ====
// Transmit shifter: one start bit, eight data bits LSB first, one stop bit.
// Assumes i_tick is a one-cycle pulse at sixteen times the bit rate.
`timescale 1ns/10ps
`default_nettype none
module uart_tx_shift
  import uart_sw_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Gating and timing
  input wire logic i_run,
  input wire logic i_tick,
  // Character load
  input wire logic i_load,
  input wire logic [CHAR_BITS-1:0] i_data,
  // Line and status
  output logic o_line,
  output logic o_busy,
  output logic o_done
);

  logic [FRAME_BITS-1:0] shift_q;
  logic [3:0] tick_cnt_q;
  logic [3:0] bit_cnt_q;
  logic busy_q;
  logic done_q;

  // ----------------------------------------------------------------
  // Shifter
  // ----------------------------------------------------------------
  // Idle shifter holds ones so the line rests at mark level
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      shift_q <= '1;
      tick_cnt_q <= 4'h0;
      bit_cnt_q <= 4'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (i_run)
    begin
      done_q <= 1'b0;
      if (!busy_q && i_load)
      begin
        shift_q <= {1'b1, i_data, 1'b0};
        tick_cnt_q <= 4'h0;
        bit_cnt_q <= 4'h0;
        busy_q <= 1'b1;
      end
      else if (busy_q && i_tick)
      begin
        tick_cnt_q <= tick_cnt_q + 4'h1;
        if (tick_cnt_q == 4'(OVERSAMPLE - 1))
        begin
          shift_q <= {1'b1, shift_q[FRAME_BITS-1:1]};
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (bit_cnt_q == 4'(FRAME_BITS - 1))
          begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
      end
    end
  end

  assign o_line = shift_q[0];
  assign o_busy = busy_q;
  assign o_done = done_q;

endmodule
`default_nettype wire

// ==== test/uart_sw_checker.sv ====
// Concurrent checks on the serial port core ports, bound to the core.
// Assumes BAUD stays at its reset value, so a frame lasts 160 clocks.
`timescale 1ns/10ps
`default_nettype none
module uart_sw_checker
  import uart_sw_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Register port
  input wire uart_sw_pkg::reg_req_t i_req,
  input wire logic [uart_sw_pkg::DATA_W-1:0] o_rdata,
  // Power control
  input wire logic i_stop_req,
  input wire logic o_wake,
  // Serial pins
  input wire logic i_serial_in_pin,
  input wire logic o_serial_in_release,
  input wire logic i_serial_out_pin,
  input wire logic o_serial_out,
  input wire logic o_serial_out_oe_b,
  // Interrupt
  input wire logic o_irq
);
  // ----------------------------------------------------------------
  // Shadow state
  // ----------------------------------------------------------------
  ctrl_t ctrl_q;
  logic [IRQ_N-1:0] irq_en_q;
  logic [7:0] gap_q;
  logic wr_ok;
  logic sw_mode;
  assign wr_ok = i_req.wr && !i_stop_req;
  assign sw_mode = ctrl_q.loopback_on && ctrl_q.rx_source_sel;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  always_ff @(posedge i_mclk or negedge i_rst_b)
    if (!i_rst_b)
      ctrl_q <= ctrl_t'(CTRL_RST);
    else if (wr_ok && i_req.addr == OFF_CTRL)
      ctrl_q <= ctrl_t'(i_req.wdata);

  always_ff @(posedge i_mclk or negedge i_rst_b)
    if (!i_rst_b)
      irq_en_q <= IRQ_EN_RST;
    else if (wr_ok && i_req.addr == OFF_IRQ_EN)
      irq_en_q <= i_req.wdata[IRQ_N-1:0];

  // Saturated gap means the shifter has surely gone idle
  always_ff @(posedge i_mclk or negedge i_rst_b)
    if (!i_rst_b)
      gap_q <= 8'hff;
    else if (i_stop_req || (wr_ok && i_req.addr == OFF_DATA))
      gap_q <= 8'h00;
    else if (gap_q != 8'hff)
      gap_q <= gap_q + 8'h01;

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_frozen;
    i_stop_req && $past(i_stop_req) |->
      $stable(o_serial_out) && $stable(o_irq) && $stable(o_serial_out_oe_b);
  endproperty
  a_frozen: assert property (p_frozen) else $error("output moved in stop");

  property p_wake_gate;
    o_wake |-> i_stop_req && irq_en_q[IRQ_RX_EDGE];
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake without enable");

  property p_wake_edge;
    i_stop_req && irq_en_q[IRQ_RX_EDGE] && ctrl_q.rx_on && !ctrl_q.loopback_on
      && $fell(i_serial_in_pin) |-> ##[1:8] (o_wake || !i_stop_req);
  endproperty
  a_wake_edge: assert property (p_wake_edge) else $error("edge gave no wake");

  property p_release;
    o_serial_in_release == sw_mode;
  endproperty
  a_release: assert property (p_release) else $error("release mismatch");

  property p_dir;
    o_serial_out_oe_b == (sw_mode && !ctrl_q.one_wire_out_dir);
  endproperty
  a_dir: assert property (p_dir) else $error("pin direction mismatch");

  property p_rdata_zero;
    (!$past(i_req.rd) || $past(i_stop_req) || $past(i_req.addr) == 3'h7
      || $past(i_req.addr) == OFF_IRQ_CLR) |-> o_rdata == '0;
  endproperty
  a_rdata_zero: assert property (p_rdata_zero) else $error("read data not zero");

  property p_irq_masked;
    irq_en_q == '0 |-> !o_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");

  property p_tx_start;
    wr_ok && i_req.addr == OFF_DATA && ctrl_q.tx_on && gap_q == 8'hff
      |-> o_serial_out ##3 !o_serial_out;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("start bit late");
endmodule
bind uart_stop_loop_single_wire uart_sw_checker uart_sw_checker_i (
  .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_req(i_req), .o_rdata(o_rdata),
  .i_stop_req(i_stop_req), .o_wake(o_wake), .i_serial_in_pin(i_serial_in_pin),
  .o_serial_in_release(o_serial_in_release), .i_serial_out_pin(i_serial_out_pin),
  .o_serial_out(o_serial_out), .o_serial_out_oe_b(o_serial_out_oe_b), .o_irq(o_irq));
`default_nettype wire

// ==== test/uart_far_end.sv ====
// Far-end serial device: sends one 8N1 frame, LSB first, on a chosen line.
// Assumes 16 module clocks per bit; the model drives both lines high at start and leaves the chosen line high after each stop bit.
`timescale 1ns/10ps
`default_nettype none
module uart_far_end
(
  // Clock
  input wire logic i_mclk,
  // Frame request
  input wire logic i_go,
  input wire logic i_port,
  input wire logic [7:0] i_byte,
  // Lines
  output logic o_in_line,
  output logic o_out_line
);
  localparam int BIT_CLKS = 16;
  logic [9:0] frame;
  // Bits change off the clock edge, as an unrelated sender would
  initial
  begin
    o_in_line = 1'b1;
    o_out_line = 1'b1;
    forever
    begin
      @(posedge i_mclk);
      while (!i_go)
        @(posedge i_mclk);
      frame = {1'b1, i_byte, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
        #7;
        if (i_port)
          o_out_line = frame[i];
        else
          o_in_line = frame[i];
        repeat (BIT_CLKS) @(posedge i_mclk);
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the serial port core and its far-end sender.
// Assumes BAUD left at reset, so one bit lasts 16 module clocks.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
    end \
  end
module testbench;
  import uart_sw_pkg::*;
  logic i_mclk;
  logic i_rst_b;
  reg_req_t req;
  logic [DATA_W-1:0] rdata;
  logic stop_req, wake, in_release, tx_line, out_oe_b, irq, out_pin;
  logic far_go, far_port, far_in, far_out;
  logic [7:0] far_byte;
  int failures, check_count;

  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  uart_stop_loop_single_wire uart_stop_loop_single_wire_i (.i_mclk(i_mclk),
    .i_rst_b(i_rst_b), .i_req(req), .o_rdata(rdata), .i_stop_req(stop_req),
    .o_wake(wake), .i_serial_in_pin(far_in), .o_serial_in_release(in_release),
    .i_serial_out_pin(out_pin), .o_serial_out(tx_line),
    .o_serial_out_oe_b(out_oe_b), .o_irq(irq));
  uart_far_end uart_far_end_i (.i_mclk(i_mclk), .i_go(far_go), .i_port(far_port),
    .i_byte(far_byte), .o_in_line(far_in), .o_out_line(far_out));
  assign out_pin = out_oe_b ? far_out : tx_line;
  always #50 i_mclk = ~i_mclk;

  // ----------------------------------------------------------------
  // Bus and line tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge i_mclk);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge i_mclk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    rd(a, d);
    `CHK(nm, e, d)
  endtask
  task automatic send(input logic port, input logic [7:0] b);
    @(posedge i_mclk);
    far_port <= port;
    far_byte <= b;
    far_go <= 1'b1;
    @(posedge i_mclk);
    far_go <= 1'b0;
  endtask
  // Polling is bounded; running out of polls counts as a mismatch
  task automatic wait_rx;
    logic [7:0] d;
    d = 8'h00;
    for (int n = 0; n < 250 && d[STAT_RX_FULL] !== 1'b1; n++)
      rd(OFF_STAT, d);
    `CHK("rx full", 1'b1, d[STAT_RX_FULL])
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd_chk(OFF_CTRL, CTRL_RST, "ctrl reset");
    rd_chk(OFF_IRQ_EN, 8'h00, "irq_en reset");
    rd_chk(3'h7, 8'h00, "unmapped");
  endtask
  task automatic t_loop;
    wr(OFF_CTRL, 8'h07);
    `CHK("release loop", 1'b0, in_release)
    send(1'b0, 8'h00);
    wr(OFF_DATA, 8'ha5);
    `CHK("oe_b loop", 1'b0, out_oe_b)
    wait_rx;
    rd_chk(OFF_DATA, 8'ha5, "loop data");
    wr(OFF_IRQ_CLR, 8'h07);
  endtask
  task automatic t_single;
    wr(OFF_CTRL, 8'h1f);
    `CHK("release single", 1'b1, in_release)
    `CHK("oe_b drive", 1'b0, out_oe_b)
    send(1'b0, 8'h00);
    wr(OFF_DATA, 8'h5a);
    wait_rx;
    rd_chk(OFF_DATA, 8'h5a, "single tx data");
    wr(OFF_CTRL, 8'h0f);
    `CHK("oe_b listen", 1'b1, out_oe_b)
    send(1'b1, 8'hc3);
    wait_rx;
    rd_chk(OFF_DATA, 8'hc3, "single rx data");
    wr(OFF_IRQ_CLR, 8'h07);
  endtask
  task automatic t_edge;
    wr(OFF_CTRL, 8'h01);
    wr(OFF_IRQ_EN, 8'h01);
    send(1'b0, 8'hff);
    wait_rx;
    rd_chk(OFF_DATA, 8'hff, "edge rx data");
    rd_chk(OFF_IRQ_STAT, 8'h05, "edge flag set");
    `CHK("irq on", 1'b1, irq)
    wr(OFF_IRQ_EN, 8'h00);
    `CHK("irq masked", 1'b0, irq)
    wr(OFF_IRQ_CLR, 8'h01);
    rd_chk(OFF_IRQ_STAT, 8'h04, "edge flag clear");
    wr(OFF_IRQ_CLR, 8'h04);
    wr(OFF_CTRL, 8'h00);
    send(1'b0, 8'hff);
    repeat (180) @(posedge i_mclk);
    rd_chk(OFF_IRQ_STAT, 8'h00, "edge rx off");
  endtask
  task automatic t_stop(input logic en);
    logic [7:0] d;
    wr(OFF_CTRL, 8'h03);
    wr(OFF_IRQ_EN, {7'h00, en});
    rd(OFF_STAT, d);
    `CHK("idle before stop", 3'b011, d[2:0])
    @(posedge i_mclk);
    stop_req <= 1'b1;
    wr(OFF_CTRL, 8'h00);
    send(1'b0, 8'hff);
    repeat (8) @(posedge i_mclk);
    #1;
    `CHK("wake", en, wake)
    `CHK("irq frozen", 1'b0, irq)
    repeat (170) @(posedge i_mclk);
    stop_req <= 1'b0;
    rd_chk(OFF_CTRL, 8'h03, "ctrl kept");
    rd_chk(OFF_IRQ_STAT, 8'h01, "flag after stop");
    wr(OFF_IRQ_CLR, 8'h07);
  endtask

  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (failures == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge i_mclk);
    failures++;
    end_sim;
  end
  initial
  begin
    i_mclk = 1'b0;
    i_rst_b = 1'b0;
    req = '0;
    stop_req = 1'b0;
    far_go = 1'b0;
    far_port = 1'b0;
    far_byte = 8'h00;
    failures = 0;
    check_count = 0;
    repeat (10) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    t_reset;
    t_loop;
    t_single;
    t_edge;
    t_stop(1'b1);
    t_stop(1'b0);
    end_sim;
  end
endmodule
`default_nettype wire
